// ==== verilog/rcoc_pkg.sv ====
// shared constants and types for the channel override control block
package rcoc_pkg;
    // register offsets
    localparam logic [7:0] REG_BOOST_ACTIVE = 8'h03;
    localparam logic [7:0] REG_TUNE_ONE = 8'h08;
    localparam logic [7:0] REG_OVR_EN = 8'h09;
    localparam logic [7:0] REG_TUNE_TWO = 8'h0b;
    localparam logic [7:0] REG_LIMIT_CTRL = 8'h13;
    localparam logic [7:0] REG_SD_OVR = 8'h14;
    localparam logic [7:0] REG_OUT_SEL = 8'h1e;
    localparam logic [7:0] REG_RATE_SEL = 8'h2f;
    localparam logic [7:0] REG_ADAPT_MODE = 8'h31;
    localparam logic [7:0] REG_SEARCH_CTRL = 8'h36;
    localparam logic [7:0] REG_BOOST_LOW = 8'h3a;
    localparam logic [7:0] REG_FAST_RES = 8'h3f;
    localparam logic [7:0] REG_BOOST_EXTRA = 8'h40;
    // field positions
    localparam int LIMIT_BIT = 2;
    localparam int OVR_TUNE_BIT = 7;
    localparam int OVR_MUX_BIT = 5;
    localparam int OVR_QCLK_BIT = 4;
    localparam int OUT_QCLK_BIT = 0;
    localparam int OUT_PATGEN_EN_BIT = 4;
    localparam int SD_FORCE_ON_BIT = 7;
    localparam int SD_FORCE_OFF_BIT = 6;
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    localparam int ADAPT_MSB = 6;
    localparam int ADAPT_LSB = 5;
    localparam int SRCH_MSB = 5;
    localparam int SRCH_LSB = 4;
    localparam int FAST_RES_DIS_BIT = 7;
    localparam int TUNE_W = 5;
    // reset values
    localparam logic [7:0] RST_OUT_SEL = 8'he0;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [1:0] SRCH_FULL = 2'h3;
    // timing: lock attempt window per tuning try
    localparam int REF_MHZ = 20;
    localparam int LOCK_TRY_US = 100;
    localparam int LOCK_TRY_CYC = REF_MHZ * LOCK_TRY_US;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        SEL_RAW = 3'h0,
        SEL_RETIMED = 3'h1,
        SEL_ICLK = 3'h2,
        SEL_QCLK = 3'h3,
        SEL_PATTERN = 3'h4,
        SEL_CLK10 = 3'h5,
        SEL_INVALID = 3'h6,
        SEL_MUTE = 3'h7
    } rcoc_sel_t;

    typedef enum logic [2:0] {
        DIV1 = 3'h0,
        DIV2 = 3'h1,
        DIV4 = 3'h2,
        DIV8 = 3'h3,
        DIV16 = 3'h4
    } rcoc_div_t;

    // register write request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } rcoc_wr_t;

    // analog status from the channel
    typedef struct packed {
        logic sig_present;
        logic locked;
        logic adapt_done;
    } rcoc_stat_t;
endpackage

// ==== verilog/rcoc_fifo.sv ====
// parameterised valid/ready fifo for register writes
`timescale 1ns/1ps
`default_nettype none
module rcoc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic do_wr;
    logic do_rd;

    assign in_ready_out = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid_out = wp_q != rp_q;
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem_q[wp_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (do_wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/rcoc_channel.sv ====
// per-channel override control: boost, tuning search, output multiplexer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - active boost register holds applied boost; writes replace it
// - limit bit puts the last equalizer stage into limiting mode
// - lock loss restarts lock/adapt sequence, which may rewrite boost
// - adapt mode zero stops adaptation rewriting boost; relock still tried
// - relock search starts at largest allowed divider when permitted
// - at divider 4 or 8, low-rate boost is copied into active boost
// - search field 11 without tuning override first runs coarse tuning search against reference
// - searched range comes from rate and subrate fields
// - tuning override values used only while override enable is set
// - override alternates value one at divide 8, value two at divide 1
// - default: mute without signal or lock, retimed data when locked
// - select field encodes mute, invalid, clocks, pattern, retimed, raw
// - without override, select applies only when present but unlocked
// - with override set, output follows the select field while signal is detected
// - no signal detected powers down channel and mutes output
// - upper override bit set, lower clear forces signal detect on
// - both override bits clear return detection to automatic
// - pattern output only when enabled; clocked by recovered or free clock
// - internal 10 MHz clock selectable under override whenever signal is detected
// - adapt mode selects equalizer adaptation after leaving reset
module rcoc_channel
    import rcoc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire rcoc_wr_t wr_in,
    input wire logic [7:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    input wire logic sig_present_in,
    input wire logic locked_in,
    input wire logic adapt_done_in,
    input wire logic [7:0] adapt_boost_in,
    output logic [7:0] boost_out,
    output logic limit_mode_out,
    output logic [TUNE_W-1:0] tune_out,
    output rcoc_div_t divider_out,
    output logic sd_active_out,
    output logic powered_out,
    output rcoc_sel_t mux_sel_out,
    output logic pattern_run_out,
    output logic pattern_free_clk_out,
    output logic fast_research_dis_out
);
    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_COARSE = 5'b00010,
        ST_TRY = 5'b00100,
        ST_ADAPT = 5'b01000,
        ST_LOCKED = 5'b10000
    } rcoc_state_t;

    // each instance owns its registers; nothing is shared between channels
    logic [7:0] boost_q;
    logic [7:0] tune1_q;
    logic [7:0] ovr_q;
    logic [7:0] tune2_q;
    logic [7:0] limit_q;
    logic [7:0] sd_q;
    logic [7:0] osel_q;
    logic [7:0] rate_q;
    logic [7:0] adapt_q;
    logic [7:0] srch_q;
    logic [7:0] blow_q;
    logic [7:0] fres_q;
    logic [7:0] bext_q;
    logic [1:0] sig_sync_q;
    logic [1:0] lock_sync_q;
    logic [1:0] adone_sync_q;
    logic sig_s;
    logic lock_s;
    logic adone_s;
    logic [15:0] aboost_sync_q;
    logic [7:0] adapt_boost_s;
    rcoc_state_t st_q;
    rcoc_div_t div_q;
    logic alt_q;
    logic [15:0] tmr_q;
    logic [TUNE_W-1:0] found_tune_q;
    logic fifo_valid;
    logic fifo_ready;
    rcoc_wr_t fifo_wr;
    logic sd_act;
    logic tune_ovr;
    logic lock_lost;
    logic tmr_done;
    logic lowrate_div;
    logic lowrate_try;
    rcoc_sel_t sel_f;

    // writes queue here so the control logic can stall during sequence updates
    rcoc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(wr_valid_in),
        .in_ready_out(wr_ready_out),
        .in_data_in(wr_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_wr)
    );

    // channel status pins are asynchronous to the reference
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sig_sync_q <= 2'h0;
            lock_sync_q <= 2'h0;
            adone_sync_q <= 2'h0;
            aboost_sync_q <= 16'h0000;
        end else begin
            sig_sync_q <= {sig_sync_q[0], sig_present_in};
            lock_sync_q <= {lock_sync_q[0], locked_in};
            adone_sync_q <= {adone_sync_q[0], adapt_done_in};
            // boost word gets the same two-flop delay as its done flag
            aboost_sync_q <= {aboost_sync_q[7:0], adapt_boost_in};
        end
    end
    assign sig_s = sig_sync_q[1];
    assign lock_s = lock_sync_q[1];
    assign adone_s = adone_sync_q[1];
    assign adapt_boost_s = aboost_sync_q[15:8];

    function automatic logic is_lowrate(input rcoc_div_t d);
        is_lowrate = (d == DIV4) || (d == DIV8);
    endfunction

    // largest divider permitted by rate/subrate code
    function automatic rcoc_div_t max_div(input logic [7:0] r);
        case (r[5:4])
            2'h0: max_div = DIV8;
            2'h1: max_div = DIV4;
            2'h2: max_div = DIV2;
            default: max_div = DIV1;
        endcase
    endfunction

    // signal detect: force off blanks (even with force on), force on alone forces detect, else automatic
    always_comb begin
        if (sd_q[SD_FORCE_ON_BIT] && !sd_q[SD_FORCE_OFF_BIT]) begin
            sd_act = 1'b1;
        end else if (!sd_q[SD_FORCE_ON_BIT] && !sd_q[SD_FORCE_OFF_BIT]) begin
            sd_act = sig_s;
        end else begin
            sd_act = 1'b0;
        end
    end

    assign tune_ovr = ovr_q[OVR_TUNE_BIT];
    assign lock_lost = !lock_s;
    assign tmr_done = tmr_q == 16'(LOCK_TRY_CYC - 1);
    assign lowrate_div = is_lowrate(div_q);
    assign lowrate_try = st_q == ST_TRY && lowrate_div;
    // all writes are held for the whole low-rate attempt unless adapt mode is zero
    assign fifo_ready = !(st_q == ST_TRY && lowrate_div && adapt_q[ADAPT_MSB:ADAPT_LSB] != 2'h0);

    // lock and adaptation sequencer
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= ST_RESET;
            div_q <= DIV1;
            alt_q <= 1'b0;
            tmr_q <= 16'h0000;
            found_tune_q <= '0;
        end else begin
            case (st_q)
                ST_RESET: begin
                    tmr_q <= 16'h0000;
                    alt_q <= 1'b0;
                    if (sd_act) begin
                        div_q <= tune_ovr ? DIV8 : max_div(rate_q);
                        if (srch_q[SRCH_MSB:SRCH_LSB] == SRCH_FULL && !tune_ovr) begin
                            st_q <= ST_COARSE;
                        end else begin
                            st_q <= ST_TRY;
                        end
                    end
                end
                ST_COARSE: begin
                    // coarse value chosen from rate field over one reference window
                    tmr_q <= tmr_q + 16'h0001;
                    if (tmr_done) begin
                        found_tune_q <= TUNE_W'({rate_q[7:6], rate_q[5:4], 1'b0});
                        tmr_q <= 16'h0000;
                        st_q <= ST_TRY;
                    end
                end
                ST_TRY: begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (!sd_act) begin
                        st_q <= ST_RESET;
                    end else if (lock_s) begin
                        st_q <= ST_ADAPT;
                    end else if (tmr_done) begin
                        tmr_q <= 16'h0000;
                        if (tune_ovr) begin
                            alt_q <= !alt_q;
                            div_q <= alt_q ? DIV8 : DIV1;
                        end else if (div_q != DIV1) begin
                            div_q <= rcoc_div_t'(div_q - 3'h1);
                        end else begin
                            div_q <= max_div(rate_q);
                        end
                    end
                end
                ST_ADAPT: begin
                    if (lock_lost || !sd_act) begin
                        st_q <= ST_RESET;
                    end else if (adone_s || adapt_q[ADAPT_MSB:ADAPT_LSB] == 2'h0) begin
                        st_q <= ST_LOCKED;
                    end
                end
                ST_LOCKED: begin
                    if (lock_lost || !sd_act) begin
                        st_q <= ST_RESET;
                    end
                end
                default: st_q <= ST_RESET;
            endcase
        end
    end

    // boost register: software writes, low-rate search copies, adaptation rewrites
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            boost_q <= RST_ZERO;
        end else if (fifo_valid && fifo_ready && fifo_wr.addr == REG_BOOST_ACTIVE) begin
            boost_q <= fifo_wr.data;
        end else if (lowrate_try) begin
            // copied in every adapt mode; pinning boost needs the low-rate value too
            boost_q <= blow_q;
        end else if (adapt_q[ADAPT_MSB:ADAPT_LSB] != 2'h0 && st_q == ST_ADAPT && adone_s) begin
            boost_q <= adapt_boost_s;
        end
    end

    // remaining software registers
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tune1_q <= RST_ZERO;
            ovr_q <= RST_ZERO;
            tune2_q <= RST_ZERO;
            limit_q <= RST_ZERO;
            sd_q <= RST_ZERO;
            osel_q <= RST_OUT_SEL;
            rate_q <= RST_ZERO;
            adapt_q <= RST_ZERO;
            srch_q <= RST_ZERO;
            blow_q <= RST_ZERO;
            fres_q <= RST_ZERO;
            bext_q <= RST_ZERO;
        end else if (fifo_valid && fifo_ready) begin
            case (fifo_wr.addr)
                REG_TUNE_ONE: tune1_q <= fifo_wr.data;
                REG_OVR_EN: ovr_q <= fifo_wr.data;
                REG_TUNE_TWO: tune2_q <= fifo_wr.data;
                REG_LIMIT_CTRL: limit_q <= fifo_wr.data;
                REG_SD_OVR: sd_q <= fifo_wr.data;
                REG_OUT_SEL: osel_q <= fifo_wr.data;
                REG_RATE_SEL: rate_q <= fifo_wr.data;
                REG_ADAPT_MODE: adapt_q <= fifo_wr.data;
                REG_SEARCH_CTRL: srch_q <= fifo_wr.data;
                REG_BOOST_LOW: blow_q <= fifo_wr.data;
                REG_FAST_RES: fres_q <= fifo_wr.data;
                REG_BOOST_EXTRA: bext_q <= fifo_wr.data;
                default: ;
            endcase
        end
    end

    // register read-back; unmapped offsets read zero
    always_comb begin
        case (rd_addr_in)
            REG_BOOST_ACTIVE: rd_data_out = boost_q;
            REG_TUNE_ONE: rd_data_out = tune1_q;
            REG_OVR_EN: rd_data_out = ovr_q;
            REG_TUNE_TWO: rd_data_out = tune2_q;
            REG_LIMIT_CTRL: rd_data_out = limit_q;
            REG_SD_OVR: rd_data_out = sd_q;
            REG_OUT_SEL: rd_data_out = osel_q;
            REG_RATE_SEL: rd_data_out = rate_q;
            REG_ADAPT_MODE: rd_data_out = adapt_q;
            REG_SEARCH_CTRL: rd_data_out = srch_q;
            REG_BOOST_LOW: rd_data_out = blow_q;
            REG_FAST_RES: rd_data_out = fres_q;
            REG_BOOST_EXTRA: rd_data_out = bext_q;
            default: rd_data_out = 8'h00;
        endcase
    end

    // output multiplexer selection
    always_comb begin
        sel_f = rcoc_sel_t'(osel_q[SEL_MSB:SEL_LSB]);
        if (!sd_act) begin
            mux_sel_out = SEL_MUTE;
        end else if (ovr_q[OVR_MUX_BIT]) begin
            // clock10 needs no lock, so it is always reachable here
            mux_sel_out = sel_f;
        end else if (st_q == ST_LOCKED || st_q == ST_ADAPT) begin
            mux_sel_out = SEL_RETIMED;
        end else begin
            mux_sel_out = sel_f;
        end
        // invalid code, or pattern without generator enabled, gives mute
        if (mux_sel_out == SEL_INVALID) begin
            mux_sel_out = SEL_MUTE;
        end
        if (mux_sel_out == SEL_PATTERN && !osel_q[OUT_PATGEN_EN_BIT]) begin
            mux_sel_out = SEL_MUTE;
        end
        // quadrature clock only with both enables, otherwise muted here
        if (mux_sel_out == SEL_QCLK && !(ovr_q[OVR_QCLK_BIT] && osel_q[OUT_QCLK_BIT])) begin
            mux_sel_out = SEL_MUTE;
        end
        // raw mode without re-search disable mutes the output
        if (mux_sel_out == SEL_RAW && !fres_q[FAST_RES_DIS_BIT]) begin
            mux_sel_out = SEL_MUTE;
        end
    end

    assign boost_out = boost_q;
    assign limit_mode_out = limit_q[LIMIT_BIT];
    assign tune_out = tune_ovr ? (div_q == DIV8 ? tune1_q[TUNE_W-1:0] : tune2_q[TUNE_W-1:0])
                               : found_tune_q;
    assign divider_out = div_q;
    assign sd_active_out = sd_act;
    assign powered_out = sd_act;
    assign pattern_run_out = osel_q[OUT_PATGEN_EN_BIT];
    assign pattern_free_clk_out = !(st_q == ST_LOCKED || st_q == ST_ADAPT);
    assign fast_research_dis_out = fres_q[FAST_RES_DIS_BIT];

    mute_nosig_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        !sd_act |-> mux_sel_out == SEL_MUTE) else $error("output not muted without signal");
    locked_ret_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sd_act && !ovr_q[OVR_MUX_BIT] && st_q == ST_LOCKED) |-> mux_sel_out == SEL_RETIMED)
        else $error("locked channel not retimed");
    force_sd_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sd_q[7:6] == 2'b10) |-> sd_act) else $error("forced detect not active");
    auto_sd_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sd_q[7:6] == 2'b00) |-> sd_act == sig_s) else $error("detect not automatic");
    adapt_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (adapt_q[6:5] == 2'h0 && !(fifo_valid && fifo_ready) && !lowrate_try)
        |=> $stable(boost_q))
        else $error("boost changed in adapt mode zero");
    lowrate_copy_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (lowrate_try && !(fifo_valid && fifo_ready)) |=> boost_q == $past(blow_q))
        else $error("low-rate boost not copied");
    alt_div_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st_q == ST_TRY && tune_ovr && tmr_done && !lock_s && sd_act)
        |=> div_q == ($past(alt_q) ? DIV8 : DIV1)) else $error("tuning not alternating");
    ovr_follow_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (sd_act && ovr_q[OVR_MUX_BIT] && osel_q[7:5] == 3'h5) |-> mux_sel_out == SEL_CLK10)
        else $error("10 MHz clock not selectable");
    lock_loss_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st_q == ST_LOCKED && !lock_s) |=> st_q == ST_RESET) else $error("no restart on lock loss");
endmodule
`default_nettype wire

// ==== testbench/rcoc_link_model.sv ====
// behavioural far side: input signal presence, lock and adaptation
`timescale 1ns/1ps
`default_nettype none
module rcoc_link_model
    import rcoc_pkg::*;
#(
    parameter int LOCK_DLY = 300,
    parameter int ADAPT_DLY = 50,
    parameter logic [7:0] BOOST = 8'h66
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic present_cmd_in,
    input wire logic lock_ok_cmd_in,
    input wire rcoc_div_t divider_in,
    output logic sig_present_out,
    output logic locked_out,
    output logic adapt_done_out,
    output logic [7:0] adapt_boost_out
);
    logic [15:0] cnt_q;
    rcoc_div_t div_q;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q <= 16'h0000;
            div_q <= DIV1;
        end else begin
            div_q <= divider_in;
            // a new divider means a new attempt, so acquisition starts over
            if (!present_cmd_in || !lock_ok_cmd_in || divider_in != div_q) begin
                cnt_q <= 16'h0000;
            end else if (cnt_q != 16'hffff) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
    assign sig_present_out = present_cmd_in;
    assign locked_out = int'(cnt_q) >= LOCK_DLY;
    assign adapt_done_out = int'(cnt_q) >= LOCK_DLY + ADAPT_DLY;
    // inverted outside the done window, so a stale sample cannot pass
    assign adapt_boost_out = adapt_done_out ? BOOST : ~BOOST;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking testbench for the channel override control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rcoc_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic [2:0] mux;
    } rcoc_row_t;
    logic ref_clk_in, reset_n_in, wr_valid, wr_ready, present, lock_ok;
    logic sig_present, locked, adapt_done, limit_mode, sd_active, powered;
    logic pat_run, pat_free, fast_dis;
    logic [7:0] rd_addr, rd_data, adapt_boost, boost;
    logic [TUNE_W-1:0] tune;
    rcoc_wr_t wr;
    rcoc_div_t divider;
    rcoc_sel_t mux_sel;
    int num_errors = 0;
    int checked = 0;
    int n;
    rcoc_row_t rows[26];

    rcoc_channel uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wr_valid_in(wr_valid),
        .wr_ready_out(wr_ready), .wr_in(wr), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .sig_present_in(sig_present), .locked_in(locked), .adapt_done_in(adapt_done),
        .adapt_boost_in(adapt_boost), .boost_out(boost), .limit_mode_out(limit_mode),
        .tune_out(tune), .divider_out(divider), .sd_active_out(sd_active),
        .powered_out(powered), .mux_sel_out(mux_sel), .pattern_run_out(pat_run),
        .pattern_free_clk_out(pat_free), .fast_research_dis_out(fast_dis));
    rcoc_link_model link (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .present_cmd_in(present), .lock_ok_cmd_in(lock_ok), .divider_in(divider),
        .sig_present_out(sig_present), .locked_out(locked), .adapt_done_out(adapt_done),
        .adapt_boost_out(adapt_boost));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // request held from a falling edge until taken, then two edges to land
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        int k;
        @(negedge ref_clk_in);
        wr_valid = 1'b1;
        wr = '{addr: a, data: d};
        k = 0;
        while (wr_ready !== 1'b1 && k < 5000) begin
            @(negedge ref_clk_in);
            k++;
        end
        if (k >= 5000) num_errors++;
        @(negedge ref_clk_in);
        wr_valid = 1'b0;
        repeat (2) @(negedge ref_clk_in);
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        num_errors++;
        final_report();
    end

    initial begin
        reset_n_in = 1'b0;
        wr_valid = 1'b0;
        wr = '0;
        rd_addr = REG_OUT_SEL;
        present = 1'b0;
        lock_ok = 1'b0;
        rows = '{'{8'h03, 8'h55, 8'h55, 3'h7}, '{8'h13, 8'h04, 8'h04, 3'h7},
            '{8'h31, 8'h00, 8'h00, 3'h7}, '{8'h3a, 8'h55, 8'h55, 3'h7},
            '{8'h40, 8'h55, 8'h55, 3'h7}, '{8'h08, 8'h0a, 8'h0a, 3'h7},
            '{8'h0b, 8'h15, 8'h15, 3'h7}, '{8'h2f, 8'h00, 8'h00, 3'h7},
            '{8'h36, 8'h00, 8'h00, 3'h7}, '{8'h3f, 8'h80, 8'h80, 3'h7},
            '{8'h50, 8'ha5, 8'h00, 3'h7}, '{8'h1e, 8'hb1, 8'hb1, 3'h7},
            '{8'h14, 8'h80, 8'h80, 3'h5}, '{8'h1e, 8'h11, 8'h11, 3'h0},
            '{8'h09, 8'h30, 8'h30, 3'h0}, '{8'h1e, 8'h31, 8'h31, 3'h1},
            '{8'h1e, 8'h51, 8'h51, 3'h2}, '{8'h1e, 8'h71, 8'h71, 3'h3},
            '{8'h1e, 8'h91, 8'h91, 3'h4}, '{8'h1e, 8'hb1, 8'hb1, 3'h5},
            '{8'h1e, 8'hd1, 8'hd1, 3'h7}, '{8'h1e, 8'hf1, 8'hf1, 3'h7},
            '{8'h1e, 8'h60, 8'h60, 3'h7}, '{8'h09, 8'h00, 8'h00, 3'h7},
            '{8'h1e, 8'he0, 8'he0, 3'h7}, '{8'h14, 8'h00, 8'h00, 3'h7}};
        repeat (20) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        #1;
        check(rd_data, RST_OUT_SEL);
        check({5'h00, mux_sel}, 8'h07);
        check({5'h00, divider}, 8'h00);
        check({7'h00, wr_ready}, 8'h01);
        for (int i = 0; i < 11; i++) begin
            rd_addr = rows[i].a;
            #1;
            check(rd_data, 8'h00);
        end
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_addr = rows[i].a;
            #1;
            check(rd_data, rows[i].rd);
            check({5'h00, mux_sel}, {5'h00, rows[i].mux});
        end
        check(boost, 8'h55);
        check({6'h00, limit_mode, fast_dis}, 8'h03);
        // tuning override alternates on a fixed attempt length
        wr_reg(REG_OVR_EN, 8'h80);
        wr_reg(REG_SD_OVR, 8'h80);
        repeat (20) @(negedge ref_clk_in);
        for (int i = 0; i < 4; i++) begin
            check({5'h00, divider}, (i % 2 == 0) ? 8'h03 : 8'h00);
            check({3'h0, tune}, (i % 2 == 0) ? 8'h0a : 8'h15);
            repeat (LOCK_TRY_CYC) @(negedge ref_clk_in);
        end
        wr_reg(REG_OVR_EN, 8'h00);
        wr_reg(REG_SD_OVR, 8'h00);
        present = 1'b1;
        lock_ok = 1'b1;
        n = 0;
        while (mux_sel !== SEL_RETIMED && n < 3000) begin
            @(negedge ref_clk_in);
            n++;
        end
        check({5'h00, mux_sel}, 8'h01);
        check(boost, 8'h55);
        check({6'h00, pat_run, pat_free}, 8'h00);
        lock_ok = 1'b0;
        repeat (10) @(negedge ref_clk_in);
        check({5'h00, mux_sel}, 8'h07);
        check(boost, 8'h55);
        check({6'h00, pat_run, pat_free}, 8'h01);
        wr_reg(REG_BOOST_LOW, 8'h33);
        check(boost, 8'h33);
        wr_reg(REG_ADAPT_MODE, 8'h20);
        present = 1'b0;
        repeat (10) @(negedge ref_clk_in);
        check({6'h00, powered, sd_active}, 8'h00);
        present = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        check({5'h00, divider}, 8'h03);
        check(boost, 8'h33);
        // queue stalls during the low-rate attempt until it is full
        for (int i = 1; i <= 8; i++) begin
            wr_reg(REG_BOOST_EXTRA, 8'(i));
        end
        check({7'h00, wr_ready}, 8'h00);
        rd_addr = REG_BOOST_EXTRA;
        #1;
        check(rd_data, 8'h55);
        lock_ok = 1'b1;
        n = 0;
        while (boost !== 8'h66 && n < 3000) begin
            @(negedge ref_clk_in);
            n++;
        end
        check(boost, 8'h66);
        repeat (20) @(negedge ref_clk_in);
        check({7'h00, wr_ready}, 8'h01);
        check(rd_data, 8'h08);
        wr_reg(REG_OUT_SEL, 8'h90);
        check({5'h00, mux_sel}, 8'h01);
        check({6'h00, pat_run, pat_free}, 8'h02);
        // full search: coarse window runs first even though the link locks early
        wr_reg(REG_RATE_SEL, 8'h10);
        wr_reg(REG_SEARCH_CTRL, 8'h30);
        present = 1'b0;
        repeat (10) @(negedge ref_clk_in);
        present = 1'b1;
        repeat (1000) @(negedge ref_clk_in);
        check({5'h00, mux_sel}, 8'h04);
        check({5'h00, divider}, 8'h02);
        check({6'h00, pat_run, pat_free}, 8'h03);
        repeat (1200) @(negedge ref_clk_in);
        check({5'h00, mux_sel}, 8'h01);
        check(boost, 8'h66);
        reset_n_in = 1'b0;
        repeat (3) @(negedge ref_clk_in);
        rd_addr = REG_OUT_SEL;
        #1;
        check(rd_data, RST_OUT_SEL);
        check(boost, 8'h00);
        check({5'h00, mux_sel}, 8'h07);
        reset_n_in = 1'b1;
        final_report();
    end
endmodule
`default_nettype wire
